// ---- core/sysopt_params.svh ----
// offsets, field positions, reset values and timing counts of the system option block
// assumes a byte-wide register port with a 4-bit register index
`ifndef SYSOPT_PARAMS_SVH
`define SYSOPT_PARAMS_SVH

// =====================================================================
// register index (byte-wide registers)
`define SYSOPT_ADDR_RESET_STATUS 4'h0
`define SYSOPT_ADDR_DEBUG_FORCE  4'h1
`define SYSOPT_ADDR_OPTIONS1     4'h2
`define SYSOPT_ADDR_OPTIONS2     4'h3
`define SYSOPT_ADDR_ID_HIGH      4'h6
`define SYSOPT_ADDR_ID_LOW       4'h7

// =====================================================================
// field positions
`define SYSOPT_DEBUG_RESET_BIT   0
`define SYSOPT_OPT2_WRITE_ONCE   8'hc0

// =====================================================================
// reset values
`define SYSOPT_OPT1_RESET        8'hc2
`define SYSOPT_OPT2_RESET        8'h00
`define SYSOPT_READ_ZERO         8'h00

// =====================================================================
// watchdog service codes
`define SYSOPT_SERVICE_FIRST     8'h55
`define SYSOPT_SERVICE_SECOND    8'haa

// =====================================================================
// watchdog timing
`define SYSOPT_LPO_PERIOD_US     1000
`define SYSOPT_WD_LPO_T1_US      32000
`define SYSOPT_WD_LPO_T2_US      256000
`define SYSOPT_WD_LPO_T3_US      1024000
`define SYSOPT_WD_LPO_C1         (`SYSOPT_WD_LPO_T1_US / `SYSOPT_LPO_PERIOD_US)
`define SYSOPT_WD_LPO_C2         (`SYSOPT_WD_LPO_T2_US / `SYSOPT_LPO_PERIOD_US)
`define SYSOPT_WD_LPO_C3         (`SYSOPT_WD_LPO_T3_US / `SYSOPT_LPO_PERIOD_US)
`define SYSOPT_WD_BUS_C1         8192
`define SYSOPT_WD_BUS_C2         65536
`define SYSOPT_WD_BUS_C3         262144
`define SYSOPT_WD_BUS_W1         6144
`define SYSOPT_WD_BUS_W2         49152
`define SYSOPT_WD_BUS_W3         196608

`endif

// ---- core/sysopt_pkg.sv ----
// types of the system option block
// field layouts of both options registers and the reset cause record
package sysopt_pkg;

  // =====================================================================
  // options register layouts
  typedef struct packed {
    logic [1:0] watchdog_timeout_sel;
    logic       stop_permit;
    logic       serial2_pin_route;
    logic       twowire_pin_route;
    logic [2:0] rsvd;
  } sysopt_opt1_t;

  typedef struct packed {
    logic       watchdog_clk_sel;
    logic       watchdog_window_mode;
    logic       rsvd_hi;
    logic       converter_trigger_sel;
    logic       rsvd_lo;
    logic [2:0] clkout_divide;
  } sysopt_opt2_t;

  // =====================================================================
  // reset cause; all zero for a debug forced reset
  typedef struct packed {
    logic watchdog;
    logic illegal_op;
  } sysopt_cause_t;

endpackage

// ---- core/sysopt_wdog.sv ----
// watchdog counter of the system option block
// assumes tick inputs are single-cycle pulses on mclk
`timescale 1ns/1ps
`include "sysopt_params.svh"
module sysopt_wdog #(
  parameter int BUS_C1 = `SYSOPT_WD_BUS_C1,
  parameter int BUS_C2 = `SYSOPT_WD_BUS_C2,
  parameter int BUS_C3 = `SYSOPT_WD_BUS_C3
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       tick_lpo,
  input  wire logic [1:0] timeout_sel,
  input  wire logic       clk_sel,
  input  wire logic       restart,
  output logic            expired_q,
  output logic            early
);

  logic [18:0] count_q;
  logic [18:0] limit;
  logic        tick;

  // =====================================================================
  // period per code, window opens at three quarters
  function automatic logic [18:0] period(input logic [1:0] sel, input logic bus);
    logic [18:0] p;
    p = 19'h00000;
    unique case (sel)
      2'b01: p = bus ? 19'(BUS_C1) : 19'(`SYSOPT_WD_LPO_C1);
      2'b10: p = bus ? 19'(BUS_C2) : 19'(`SYSOPT_WD_LPO_C2);
      2'b11: p = bus ? 19'(BUS_C3) : 19'(`SYSOPT_WD_LPO_C3);
      2'b00: p = 19'h00000;
    endcase
    return p;
  endfunction

  assign limit = period(timeout_sel, clk_sel);
  assign tick  = clk_sel ? 1'b1 : tick_lpo;
  // bus codes give 6144/49152/196608, the same three quarters
  assign early = count_q < (limit - (limit >> 2));

  // =====================================================================
  // counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q   <= 19'h00000;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (timeout_sel == 2'b00 || restart) begin
        count_q <= 19'h00000;
      end else if (tick) begin
        if (count_q == limit - 19'h00001) begin
          count_q   <= 19'h00000;
          expired_q <= 1'b1;
        end else begin
          count_q <= count_q + 19'h00001;
        end
      end
    end
  end

endmodule

// ---- core/sysopt_ctrl.sv ----
// system option and control registers with watchdog, stop guard and clock output
// assumes a byte register port from the cpu, a background debug write port and an
// external reset controller that turns reset_req_q into a pulse on arst_n
`timescale 1ns/1ps
`include "sysopt_params.svh"
module sysopt_ctrl #(
  parameter logic [11:0] PART_ID  = 12'h0a5, // arbitrary value
  parameter logic [3:0]  REVISION = 4'h1,    // arbitrary value
  parameter int          BUS_C1   = `SYSOPT_WD_BUS_C1,
  parameter int          BUS_C2   = `SYSOPT_WD_BUS_C2,
  parameter int          BUS_C3   = `SYSOPT_WD_BUS_C3
) (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire logic                     cpu_wr,
  input  wire logic                     cpu_rd,
  input  wire logic [3:0]               cpu_addr,
  input  wire logic [7:0]               cpu_wdata,
  output logic      [7:0]               cpu_rdata_q,
  input  wire logic                     dbg_wr,
  input  wire logic [3:0]               dbg_addr,
  input  wire logic [7:0]               dbg_wdata,
  input  wire logic                     lpo_clk,
  input  wire logic                     stop_exec,
  output logic                          stop_grant_q,
  input  wire logic                     converter_hw_trigger_en,
  input  wire logic                     rtc_ovf,
  input  wire logic                     irq_pin,
  output logic                          converter_trigger_q,
  output logic                          serial2_pin_route_q,
  output logic                          twowire_pin_route_q,
  output logic                          port_a_pin0_q,
  output logic                          port_a_pin0_oe_q,
  output logic                          reset_req_q,
  output sysopt_pkg::sysopt_cause_t     reset_cause_q
);

  sysopt_pkg::sysopt_opt1_t opt1_q;
  sysopt_pkg::sysopt_opt2_t opt2_q;
  logic        opt1_done_q;
  logic        opt2_done_q;
  logic        armed_q;
  logic [2:0]  lpo_sync_q;
  logic [1:0]  irq_sync_q;
  logic [2:0]  div_cnt_q;
  logic        wd_expired;
  logic        wd_early;
  logic        wd_restart;
  logic        wd_enabled;
  logic        user_wr;
  logic        status_wr;
  logic        service_bad;
  logic        debug_force;
  logic        illegal_stop;

  // =====================================================================
  // decode
  function automatic logic hit(input logic wr, input logic [3:0] a, input logic [3:0] r);
    return wr && (a == r);
  endfunction

  // debug writes the options registers through the same path as the cpu; only the cpu reaches the status register
  assign user_wr   = cpu_wr && !dbg_wr;
  assign status_wr = hit(user_wr, cpu_addr, `SYSOPT_ADDR_RESET_STATUS);
  // only the background port reaches the force bit
  assign debug_force = hit(dbg_wr, dbg_addr, `SYSOPT_ADDR_DEBUG_FORCE)
                       && dbg_wdata[`SYSOPT_DEBUG_RESET_BIT];
  assign wd_enabled  = opt1_q.watchdog_timeout_sel != 2'b00;
  assign wd_restart  = status_wr && armed_q
                       && cpu_wdata == `SYSOPT_SERVICE_SECOND && !wd_bad_window();
  assign service_bad = status_wr && wd_enabled
                       && ((cpu_wdata != `SYSOPT_SERVICE_FIRST
                            && cpu_wdata != `SYSOPT_SERVICE_SECOND)
                           || wd_bad_window());
  assign illegal_stop = stop_exec && !opt1_q.stop_permit;

  // in window mode software can only service in the last quarter of the period
  function automatic logic wd_bad_window();
    return opt2_q.watchdog_window_mode && wd_enabled && wd_early;
  endfunction

  // =====================================================================
  // common write port
  logic       any_wr;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  assign any_wr  = cpu_wr || dbg_wr;
  assign wr_addr = dbg_wr ? dbg_addr : cpu_addr;
  assign wr_data = dbg_wr ? dbg_wdata : cpu_wdata;

  // =====================================================================
  // first options register, write once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opt1_q      <= sysopt_pkg::sysopt_opt1_t'(`SYSOPT_OPT1_RESET);
      opt1_done_q <= 1'b0;
    end else if (hit(any_wr, wr_addr, `SYSOPT_ADDR_OPTIONS1) && !opt1_done_q) begin
      opt1_q      <= sysopt_pkg::sysopt_opt1_t'({wr_data[7:3], 3'h0});
      opt1_done_q <= 1'b1;
    end
  end

  // =====================================================================
  // second options register: top two bits write once, bits 4 and 2:0 free, bits 5 and 3 stay zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opt2_q      <= sysopt_pkg::sysopt_opt2_t'(`SYSOPT_OPT2_RESET);
      opt2_done_q <= 1'b0;
    end else if (hit(any_wr, wr_addr, `SYSOPT_ADDR_OPTIONS2)) begin
      opt2_q.converter_trigger_sel <= wr_data[4];
      opt2_q.clkout_divide         <= wr_data[2:0];
      opt2_done_q                  <= 1'b1;
      if (!opt2_done_q) begin
        opt2_q.watchdog_clk_sel     <= wr_data[7];
        opt2_q.watchdog_window_mode <= wr_data[6];
      end
    end
  end

  // =====================================================================
  // watchdog service sequence
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b0;
    end else if (status_wr) begin
      armed_q <= cpu_wdata == `SYSOPT_SERVICE_FIRST;
    end
  end

  // =====================================================================
  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lpo_sync_q <= 3'h0;
      irq_sync_q <= 2'h0;
    end else begin
      lpo_sync_q <= {lpo_sync_q[1:0], lpo_clk};
      irq_sync_q <= {irq_sync_q[0], irq_pin};
    end
  end

  sysopt_wdog #(
    .BUS_C1 (BUS_C1),
    .BUS_C2 (BUS_C2),
    .BUS_C3 (BUS_C3)
  ) u_wdog (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .tick_lpo    (lpo_sync_q[1] && !lpo_sync_q[2]),
    .timeout_sel (opt1_q.watchdog_timeout_sel),
    .clk_sel     (opt2_q.watchdog_clk_sel),
    .restart     (wd_restart),
    .expired_q   (wd_expired),
    .early       (wd_early)
  );

  // =====================================================================
  // reset request; held until the system reset clears it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_req_q   <= 1'b0;
      reset_cause_q <= '0;
    end else if (!reset_req_q) begin
      if (debug_force) begin
        reset_req_q   <= 1'b1;
        reset_cause_q <= '0;
      end else if (wd_expired || service_bad) begin
        reset_req_q            <= 1'b1;
        reset_cause_q.watchdog <= 1'b1;
      end else if (illegal_stop) begin
        reset_req_q              <= 1'b1;
        reset_cause_q.illegal_op <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stop_grant_q <= 1'b0;
    end else begin
      stop_grant_q <= stop_exec && opt1_q.stop_permit;
    end
  end

  // =====================================================================
  // routing and converter trigger
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      serial2_pin_route_q <= 1'b0;
      twowire_pin_route_q <= 1'b0;
      converter_trigger_q <= 1'b0;
    end else begin
      serial2_pin_route_q <= opt1_q.serial2_pin_route;
      twowire_pin_route_q <= opt1_q.twowire_pin_route;
      converter_trigger_q <= converter_hw_trigger_en
                             && (opt2_q.converter_trigger_sel ? irq_sync_q[1]
                                                              : rtc_ovf);
    end
  end

  // =====================================================================
  // clock output: toggles every divide cycles, so period is twice divide
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q        <= 3'h0;
      port_a_pin0_q    <= 1'b0;
      port_a_pin0_oe_q <= 1'b0;
    end else if (opt2_q.clkout_divide == 3'h0) begin
      div_cnt_q        <= 3'h0;
      port_a_pin0_q    <= 1'b0;
      port_a_pin0_oe_q <= 1'b0;
    end else begin
      port_a_pin0_oe_q <= 1'b1;
      if (div_cnt_q >= opt2_q.clkout_divide - 3'h1) begin
        div_cnt_q     <= 3'h0;
        port_a_pin0_q <= !port_a_pin0_q;
      end else begin
        div_cnt_q <= div_cnt_q + 3'h1;
      end
    end
  end

  // =====================================================================
  // read port; status register reads belong to the reset controller
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_rdata_q <= `SYSOPT_READ_ZERO;
    end else if (cpu_rd) begin
      unique case (cpu_addr)
        `SYSOPT_ADDR_OPTIONS1: cpu_rdata_q <= opt1_q;
        `SYSOPT_ADDR_OPTIONS2: cpu_rdata_q <= opt2_q;
        `SYSOPT_ADDR_ID_HIGH:  cpu_rdata_q <= {REVISION, PART_ID[11:8]};
        `SYSOPT_ADDR_ID_LOW:   cpu_rdata_q <= PART_ID[7:0];
        `SYSOPT_ADDR_DEBUG_FORCE: cpu_rdata_q <= `SYSOPT_READ_ZERO;
        default:               cpu_rdata_q <= `SYSOPT_READ_ZERO;
      endcase
    end
  end

endmodule

// ---- tb/sysopt_ctrl_props.sv ----
// checker of the system option block: timing relations at its ports
// assumes it is bound to sysopt_ctrl and that everything runs on mclk
`timescale 1ns/1ps
module sysopt_ctrl_props #(
  parameter logic [11:0] PART_ID  = 12'h0a5,
  parameter logic [3:0]  REVISION = 4'h1
) (
  input wire logic                 mclk,
  input wire logic                 arst_n,
  input wire logic                 cpu_wr,
  input wire logic                 cpu_rd,
  input wire logic [3:0]           cpu_addr,
  input wire logic [7:0]           cpu_rdata_q,
  input wire logic                 dbg_wr,
  input wire logic [3:0]           dbg_addr,
  input wire logic [7:0]           dbg_wdata,
  input wire logic                 stop_exec,
  input wire logic                 stop_grant_q,
  input wire logic                 converter_hw_trigger_en,
  input wire logic                 converter_trigger_q,
  input wire logic                 serial2_pin_route_q,
  input wire logic                 twowire_pin_route_q,
  input wire logic                 port_a_pin0_q,
  input wire logic                 port_a_pin0_oe_q,
  input wire logic                 reset_req_q,
  input wire sysopt_pkg::sysopt_cause_t reset_cause_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // =====================================================================
  // assertions
  dbg_force_a: assert property (dbg_wr && dbg_addr == 4'h1 && dbg_wdata[0] && !reset_req_q
    |=> reset_req_q && reset_cause_q == 2'b00) else $error("debug reset missing");
  req_hold_a: assert property (reset_req_q |=> reset_req_q)
    else $error("reset request dropped");
  force_read_a: assert property (cpu_rd && cpu_addr == 4'h1 |=> cpu_rdata_q == 8'h00)
    else $error("force reg not zero");
  id_high_a: assert property (cpu_rd && cpu_addr == 4'h6 |=> cpu_rdata_q == {REVISION,
    PART_ID[11:8]}) else $error("id high wrong");
  id_low_a: assert property (cpu_rd && cpu_addr == 4'h7 |=> cpu_rdata_q == PART_ID[7:0])
    else $error("id low wrong");
  rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata_q))
    else $error("read data moved");
  route_cause_a: assert property ($changed({serial2_pin_route_q, twowire_pin_route_q})
    |-> $past(cpu_wr && cpu_addr == 4'h2 || dbg_wr && dbg_addr == 4'h2, 2)
    || $past(cpu_wr && cpu_addr == 4'h2 || dbg_wr && dbg_addr == 4'h2))
    else $error("route moved unwritten");
  clkout_off_a: assert property (!port_a_pin0_oe_q |-> !port_a_pin0_q)
    else $error("clock out driven");
  stop_answer_a: assert property (stop_exec && !reset_req_q |=> stop_grant_q || reset_req_q)
    else $error("stop unanswered");
  grant_cause_a: assert property (stop_grant_q |-> $past(stop_exec))
    else $error("stray stop grant");
  trig_gate_a: assert property (converter_trigger_q |-> $past(converter_hw_trigger_en))
    else $error("trigger while disabled");
  cover property (dbg_wr && dbg_addr == 4'h1 ##1 reset_req_q);
  cover property (stop_grant_q);
  cover property (port_a_pin0_oe_q && $rose(port_a_pin0_q));
endmodule

// ---- tb/sysopt_dbg_host.sv ----
// background debug host model: issues single byte writes on the debug port
// assumes the device samples dbg_wr on the rising edge of mclk
`timescale 1ns/1ps
module sysopt_dbg_host (
  input  wire logic       mclk,
  output logic            dbg_wr,
  output logic [3:0]      dbg_addr,
  output logic [7:0]      dbg_wdata
);
  initial begin
    dbg_wr = 1'b0;
    dbg_addr = 4'h0;
    dbg_wdata = 8'h00;
  end
  // lines are scrambled after release so a stale command never looks live
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    dbg_wr = 1'b1;
    dbg_addr = a;
    dbg_wdata = d;
    @(negedge mclk);
    dbg_wr = 1'b0;
    dbg_addr = ~a;
    dbg_wdata = ~d;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench of the system option block
// assumes the design, its checker and the debug host model are compiled first
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] PID = 12'h3c7; // arbitrary value
  localparam logic [3:0]  REV = 4'h2;    // arbitrary value
  localparam int          LPO = 10;      // low-power clock period in mclk cycles
  logic        mclk, arst_n, cpu_wr, cpu_rd, stop_exec, stop_grant_q, rtc_ovf, irq_pin;
  logic        lpo_clk, converter_hw_trigger_en, converter_trigger_q, reset_req_q;
  logic        serial2_pin_route_q, twowire_pin_route_q, port_a_pin0_q, port_a_pin0_oe_q;
  logic        dbg_wr, b0;
  logic [3:0]  cpu_addr, dbg_addr;
  logic [7:0]  cpu_wdata, cpu_rdata_q, dbg_wdata, v;
  logic [2:0]  div;
  int          mismatches, check_count, n, p, seed;
  sysopt_pkg::sysopt_cause_t reset_cause_q;

  sysopt_ctrl #(.PART_ID(PID), .REVISION(REV), .BUS_C1(64), .BUS_C2(128), .BUS_C3(256)) dut (
    .mclk, .arst_n, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .cpu_rdata_q, .dbg_wr,
    .dbg_addr, .dbg_wdata, .lpo_clk, .stop_exec, .stop_grant_q, .converter_hw_trigger_en,
    .rtc_ovf, .irq_pin, .converter_trigger_q, .serial2_pin_route_q, .twowire_pin_route_q,
    .port_a_pin0_q, .port_a_pin0_oe_q, .reset_req_q, .reset_cause_q);
  sysopt_dbg_host host (.mclk, .dbg_wr, .dbg_addr, .dbg_wdata);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // free-running slow clock, phase unrelated to mclk
  initial begin
    lpo_clk = 1'b0;
    #3;
    forever #(LPO * 4) lpo_clk = ~lpo_clk;
  end

  // =====================================================================
  // helpers
  function automatic int period(logic bus, int c);
    return bus ? (64 << (c - 1)) : LPO * ((c == 1) ? 32 : (c == 2) ? 256 : 1024);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge mclk);
    cpu_wr = 1'b0;
    cpu_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge mclk);
    cpu_rd = 1'b0;
    chk("rdata", {24'h0, e}, {24'h0, cpu_rdata_q});
  endtask
  task automatic rst();
    arst_n = 1'b0;
    wait_n(3);
    arst_n = 1'b1;
  endtask
  task automatic svc();
    wr(4'h0, 8'h55);
    wr(4'h0, 8'haa);
  endtask
  task automatic summarize();
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(80000 * 8);
    mismatches++;
    summarize();
  end

  // =====================================================================
  // main sequence
  initial begin
    seed = 32'h90e9549c;
    {cpu_wr, cpu_rd, stop_exec, converter_hw_trigger_en, rtc_ovf, irq_pin} = '0;
    cpu_addr = 4'h0;
    cpu_wdata = 8'h00;
    rst();
    rd(4'h2, 8'hc2);
    rd(4'h3, 8'h00);
    rd(4'h9, 8'h00);
    v = {3'b001, 2'($random(seed)), 3'b000};
    wr(4'h2, v);
    wr(4'h2, ~v);
    rd(4'h2, v);
    chk("routes", v[4:3], {serial2_pin_route_q, twowire_pin_route_q});
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h3c);
    wr(4'h6, 8'($random(seed)));
    wr(4'h7, 8'($random(seed)));
    wait_n(4);
    chk("no_reset", 0, reset_req_q);
    rd(4'h6, {REV, PID[11:8]});
    rd(4'h7, PID[7:0]);
    rd(4'h1, 8'h00);
    div = 3'(1 + ($unsigned($random(seed)) % 7));
    wr(4'h3, 8'hbd);
    rd(4'h3, 8'h95);
    wr(4'h3, 8'h50 | {5'h00, div});
    rd(4'h3, 8'h90 | {5'h00, div});
    converter_hw_trigger_en = 1'b1;
    rtc_ovf = 1'b1;
    wait_n(1);
    rtc_ovf = 1'b0;
    chk("trig_rtc_ignored", 0, converter_trigger_q);
    irq_pin = 1'b1;
    wait_n(4);
    chk("trig_irq", 1, converter_trigger_q);
    irq_pin = 1'b0;
    chk("clkout_oe", 1, port_a_pin0_oe_q);
    b0 = port_a_pin0_q;
    while (port_a_pin0_q === b0) @(negedge mclk);
    n = 0;
    b0 = port_a_pin0_q;
    while (port_a_pin0_q === b0 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("clkout_half", div, n);
    wr(4'h3, 8'h00);
    rtc_ovf = 1'b1;
    wait_n(1);
    rtc_ovf = 1'b0;
    chk("trig_rtc", 1, converter_trigger_q);
    wait_n(2);
    chk("clkout_off", 0, {port_a_pin0_oe_q, port_a_pin0_q});
    stop_exec = 1'b1;
    wait_n(1);
    stop_exec = 1'b0;
    chk("stop_grant", 1, stop_grant_q);
    host.write_byte(4'h1, 8'h01);
    chk("dbg_reset", 3'b100, {reset_req_q, reset_cause_q});
    rst();
    rd(4'h2, 8'hc2);
    stop_exec = 1'b1;
    wait_n(1);
    stop_exec = 1'b0;
    wait_n(1);
    chk("stop_reset", 3'b101, {reset_req_q, reset_cause_q});
    rst();
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    for (int b = 0; b < 2; b++) begin
      for (int c = 1; c < 4; c++) begin
        rst();
        wr(4'h3, {b[0], 7'h00});
        wr(4'h2, {c[1:0], 6'h20});
        p = period(b[0], c);
        repeat (2) begin
          wait_n(p / 2);
          svc();
        end
        n = 0;
        while (reset_req_q !== 1'b1 && n < 12000) begin
          @(negedge mclk);
          n++;
        end
        chk("wd_period", 1, n >= p - (b ? 1 : LPO + 4) && n <= p + (b ? 4 : LPO + 6));
        chk("wd_cause", 3'b110, {reset_req_q, reset_cause_q});
      end
    end
    rst();
    wr(4'h3, 8'h80);
    wr(4'h2, 8'h40);
    wr(4'h0, 8'h5a);
    wait_n(1);
    chk("bad_service", 3'b110, {reset_req_q, reset_cause_q});
    rst();
    wr(4'h3, 8'hc0);
    wr(4'h2, 8'h40);
    wr(4'h0, 8'h55);
    wait_n(1);
    chk("early_service", 3'b110, {reset_req_q, reset_cause_q});
    rst();
    wr(4'h3, 8'hc0);
    wr(4'h2, 8'h40);
    wait_n(50);
    svc();
    wait_n(30);
    chk("window_service", 0, reset_req_q);
    summarize();
  end
endmodule

bind sysopt_ctrl sysopt_ctrl_props #(.PART_ID(PART_ID), .REVISION(REVISION)) props (
  .mclk, .arst_n, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_rdata_q, .dbg_wr, .dbg_addr, .dbg_wdata,
  .stop_exec, .stop_grant_q, .converter_hw_trigger_en, .converter_trigger_q,
  .serial2_pin_route_q, .twowire_pin_route_q, .port_a_pin0_q, .port_a_pin0_oe_q,
  .reset_req_q, .reset_cause_q);
